/* File: logic/rtpwm_output.sv */
// Output waveform logic of a ratiometric PWM temperature sensor
// Function
// R1: High time fixed, low time follows the measured temperature.
// R2: Nominal rate at 25 C gives about 99 ms period.
// R3: Mode strap sampled once: low one shot, float continuous, high chain.
// R4: Continuous mode emits waveforms back to back without requests.
// R5: Rate strap captured once at power-up, later changes ignored.
// R6: One shot mode gives one waveform per request, else idle.
// R7: Controller requests by pulling the line low then releasing it.
// R8: Requests last over 20 ns; shorter low pulses are ignored.
// R9: Waveform starts after release, first rising edge follows it.
// R10: One shot mode switches series resistance into high-side driver.
// R11: Rate strap scales high and low times: quarter, nominal, double/quarter.
// R12: Controller times high and following low with one clock, uses ratio.
// R13: Low or float rate: temperature is 421 minus 751 times ratio.
// R14: Controller picks its formula by rate setting.
// R15: Chain mode uses the rate pin as the chain input.
// R16: Each cycle is high interval first, then low interval.
`timescale 1ns/1ps

module rtpwm_output
  import rtpwm_pkg::*;
#(
  parameter logic [TIME_W-1:0] TH_NOM_US = TH_NOM_US_DEF, // R2
  parameter int unsigned       TICK_CYC  = TICK_CYC_DEF
) (
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  input  wire rtpwm_lvl_t        mode_select_pin_i,
  input  wire rtpwm_lvl_t        rate_select_chain_input_pin_i,
  input  wire logic [TIME_W-1:0] low_time_us_i,
  input  wire logic              out_i,
  output logic                   out_o,
  output logic                   out_oe_o,
  output logic                   series_res_en_o,
  output logic                   busy_o
);

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);
  localparam logic [REQ_W-1:0]  REQ_LAST  = REQ_W'(REQ_MIN_CYC - 1);

  rtpwm_state_t st_reg;
  rtpwm_state_t st_next;
  logic         tick;
  logic         phase_done;
  logic         req_low;

  // ****************************************************************
  // Next state
  // ****************************************************************
  assign tick       = (st_reg.tick_cnt == TICK_LAST);
  assign phase_done = tick && (st_reg.time_cnt == st_reg.phase_len - 1'b1);
  // In chain mode the rate pin carries the start pulse instead
  assign req_low    = (st_reg.mode == MODE_CHAIN) ?
                      (rate_select_chain_input_pin_i == LVL_LOW) : !out_i; // R15 R7

  always_comb begin
    st_next = st_reg;
    st_next.tick_cnt = tick ? '0 : st_reg.tick_cnt + 1'b1;
    unique case (st_reg.fsm)
      ST_STRAP: begin
        unique case (mode_select_pin_i) // R3
          LVL_LOW:   st_next.mode = MODE_ONESHOT;
          LVL_FLOAT: st_next.mode = MODE_CONT;
          default:   st_next.mode = MODE_CHAIN;
        endcase
        unique case (rate_select_chain_input_pin_i) // R5
          LVL_LOW:   st_next.rate = RATE_QUARTER;
          LVL_FLOAT: st_next.rate = RATE_NOMINAL;
          default:   st_next.rate = RATE_DBL_HIGH;
        endcase
        if (mode_select_pin_i == LVL_HIGH) begin
          st_next.rate = RATE_NOMINAL; // R15
        end
        if (mode_select_pin_i == LVL_FLOAT) begin
          st_next.fsm       = ST_HIGH; // R4
          st_next.tick_cnt  = '0;
          st_next.time_cnt  = '0;
          st_next.phase_len = rtpwm_scale_high(st_next.rate, TH_NOM_US);
        end else begin
          st_next.fsm = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (req_low) begin
          // Saturating count of consecutive low samples
          if (st_reg.req_cnt != REQ_LAST) begin
            st_next.req_cnt = st_reg.req_cnt + 1'b1;
          end else begin
            st_next.req_armed = 1'b1; // R8
          end
        end else begin
          st_next.req_cnt   = '0;
          st_next.req_armed = 1'b0;
          if (st_reg.req_armed) begin
            st_next.fsm       = ST_HIGH; // R6 R9
            st_next.tick_cnt  = '0;
            st_next.time_cnt  = '0;
            st_next.phase_len = rtpwm_scale_high(st_reg.rate, TH_NOM_US); // R11
          end
        end
      end
      ST_HIGH: begin
        if (tick) begin
          st_next.time_cnt = st_reg.time_cnt + 1'b1;
        end
        if (phase_done) begin
          // Low time taken from low_time_us_i when the high phase ends
          st_next.fsm       = ST_LOW; // R16 R1
          st_next.time_cnt  = '0;
          st_next.phase_len = rtpwm_scale_low(st_reg.rate, low_time_us_i); // R11
        end
      end
      ST_LOW: begin
        if (tick) begin
          st_next.time_cnt = st_reg.time_cnt + 1'b1;
        end
        if (phase_done) begin
          st_next.time_cnt = '0;
          st_next.req_cnt  = '0;
          if (st_reg.mode == MODE_CONT) begin
            st_next.fsm       = ST_HIGH; // R4
            st_next.phase_len = rtpwm_scale_high(st_reg.rate, TH_NOM_US);
          end else begin
            st_next.fsm = ST_IDLE; // R6
          end
        end
      end
    endcase

    // ****************************************************************
    // Line drive
    // ****************************************************************
    st_next.line.series_res = (st_next.mode == MODE_ONESHOT) && (st_next.fsm != ST_STRAP); // R10
    st_next.line.oe         = (st_next.fsm != ST_STRAP);
    unique case (st_next.fsm)
      ST_STRAP: st_next.line.level = 1'b0;
      ST_HIGH:  st_next.line.level = 1'b1; // R1
      ST_LOW:   st_next.line.level = 1'b0;
      ST_IDLE:  begin
        // One shot idles high through the resistor; chain idles as a buffer
        if (st_next.mode == MODE_CHAIN) begin
          st_next.line.level = (rate_select_chain_input_pin_i != LVL_LOW);
        end else begin
          st_next.line.level = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_reg <= RST_STATE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign out_o           = st_reg.line.level;
  assign out_oe_o        = st_reg.line.oe;
  assign series_res_en_o = st_reg.line.series_res;
  assign busy_o          = (st_reg.fsm == ST_HIGH) || (st_reg.fsm == ST_LOW);

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  // Cycle count within the current phase, for length checks
  logic [31:0] phase_cyc;
  logic [TIME_W-1:0] high_expect;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      phase_cyc <= '0;
    end else if (st_reg.fsm != st_next.fsm) begin
      phase_cyc <= '0;
    end else begin
      phase_cyc <= phase_cyc + 1'b1;
    end
  end
  assign high_expect = rtpwm_scale_high(st_reg.rate, TH_NOM_US);

  sequence s_idle_short_pulse;
    (st_reg.fsm == ST_IDLE && st_reg.mode == MODE_ONESHOT && out_i) ##1
    (!out_i)[*5] ##1 out_i;
  endsequence

  sequence s_idle_valid_req;
    (st_reg.fsm == ST_IDLE && st_reg.mode == MODE_ONESHOT && out_i) ##1
    (!out_i)[*6] ##1 out_i;
  endsequence

  a_short_pulse_ignored: assert property ( // R8
    s_idle_short_pulse |=> st_reg.fsm == ST_IDLE && out_o)
    else $error("short low pulse started a waveform");

  a_valid_req_starts: assert property ( // R9
    s_idle_valid_req |=> st_reg.fsm == ST_HIGH && out_o)
    else $error("valid request did not start high phase after release");

  a_high_no_early: assert property ( // R9
    (st_reg.fsm == ST_IDLE && st_reg.mode == MODE_ONESHOT && !out_i) |=>
    st_reg.fsm == ST_IDLE)
    else $error("waveform started while line still held low");

  a_high_length: assert property ( // R1
    (st_reg.fsm == ST_HIGH && st_next.fsm == ST_LOW) |->
    phase_cyc + 1 == 32'(high_expect) * TICK_CYC)
    else $error("high phase length wrong");

  a_low_length: assert property ( // R11
    (st_reg.fsm == ST_LOW && st_next.fsm != ST_LOW) |->
    phase_cyc + 1 == 32'(st_reg.phase_len) * TICK_CYC)
    else $error("low phase length wrong");

  a_high_then_low: assert property ( // R16
    (st_reg.fsm == ST_HIGH && st_next.fsm != ST_HIGH) |=>
    st_reg.fsm == ST_LOW && !out_o)
    else $error("high phase not followed by low phase");

  a_cont_back_back: assert property ( // R4
    (st_reg.mode == MODE_CONT && st_reg.fsm == ST_LOW && phase_done) |=>
    st_reg.fsm == ST_HIGH && out_o)
    else $error("continuous mode did not restart");

  a_oneshot_single: assert property ( // R6
    (st_reg.mode == MODE_ONESHOT && st_reg.fsm == ST_LOW && phase_done) |=>
    st_reg.fsm == ST_IDLE ##1 st_reg.fsm == ST_IDLE)
    else $error("one shot produced more than one waveform");

  a_straps_stable: assert property ( // R5
    (st_reg.fsm != ST_STRAP) |=> $stable(st_reg.mode) && $stable(st_reg.rate))
    else $error("strap value changed after power-up");

  a_strap_mode_map: assert property ( // R3
    (st_reg.fsm == ST_STRAP && mode_select_pin_i == LVL_LOW) |=>
    st_reg.mode == MODE_ONESHOT && st_reg.fsm == ST_IDLE)
    else $error("low mode strap did not select one shot");

  a_series_res: assert property ( // R10
    (st_reg.fsm != ST_STRAP) |-> series_res_en_o == (st_reg.mode == MODE_ONESHOT))
    else $error("series resistance wrong for mode");

  a_chain_nominal: assert property ( // R15
    (st_reg.fsm != ST_STRAP && st_reg.mode == MODE_CHAIN) |->
    st_reg.rate == RATE_NOMINAL)
    else $error("chain mode not at nominal rate");

  // ****************************************************************
  // Rate, level and chain checks
  // ****************************************************************
  // Start pulse on the chain input, the same shape as a one shot request
  sequence s_chain_start_pulse;
    (st_reg.fsm == ST_IDLE && st_reg.mode == MODE_CHAIN &&
     rate_select_chain_input_pin_i != LVL_LOW) ##1
    (rate_select_chain_input_pin_i == LVL_LOW)[*6] ##1
    (rate_select_chain_input_pin_i != LVL_LOW);
  endsequence

  a_chain_start: assert property ( // R15
    s_chain_start_pulse |=> st_reg.fsm == ST_HIGH && busy_o)
    else $error("chain start pulse did not start a waveform");

  a_chain_buffer: assert property ( // R15
    (st_reg.fsm == ST_IDLE && st_reg.mode == MODE_CHAIN && st_next.fsm == ST_IDLE) |=>
    out_o == ($past(rate_select_chain_input_pin_i) != LVL_LOW))
    else $error("idle chain output does not follow its input");

  a_cont_no_idle: assert property ( // R4
    (st_reg.mode == MODE_CONT && st_reg.fsm != ST_STRAP) |-> busy_o)
    else $error("continuous mode went idle");

  a_oneshot_idle_high: assert property ( // R10
    (st_reg.mode == MODE_ONESHOT && st_reg.fsm == ST_IDLE) |->
    out_o && out_oe_o && series_res_en_o)
    else $error("one shot idle line not held high through resistor");

  a_oe_after_strap: assert property ( // R1
    (st_reg.fsm != ST_STRAP) |-> out_oe_o)
    else $error("line not driven after straps were taken");

  a_high_drives_one: assert property ( // R1
    (st_reg.fsm == ST_HIGH) |-> out_o && busy_o)
    else $error("high phase not driving one");

  a_low_drives_zero: assert property ( // R1
    (st_reg.fsm == ST_LOW) |-> !out_o && busy_o)
    else $error("low phase not driving zero");

  // Tiny high times clamp to one tick; the guard keeps the check exact
  a_high_len_rate: assert property ( // R11
    (st_next.fsm == ST_HIGH && st_reg.fsm != ST_HIGH && (TH_NOM_US >> 2) != '0) |=>
    st_reg.phase_len == ((st_reg.rate == RATE_DBL_HIGH) ? (TH_NOM_US << 1) :
                         (st_reg.rate == RATE_QUARTER)  ? (TH_NOM_US >> 2) : TH_NOM_US))
    else $error("high time not scaled by the rate strap");

  a_low_len_nominal: assert property ( // R11
    (st_reg.fsm == ST_HIGH && phase_done && st_reg.rate == RATE_NOMINAL &&
     low_time_us_i != '0) |=> st_reg.phase_len == $past(low_time_us_i))
    else $error("nominal low time not taken unscaled");

  a_low_len_quarter: assert property ( // R11
    (st_reg.fsm == ST_HIGH && phase_done && st_reg.rate != RATE_NOMINAL &&
     (low_time_us_i >> 2) != '0) |=> st_reg.phase_len == ($past(low_time_us_i) >> 2))
    else $error("low time not quartered");

endmodule // rtpwm_output

/* File: logic/rtpwm_pkg.sv */
// Shared constants, types and helpers of the ratiometric temperature PWM output
package rtpwm_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_NS       = 4;
  localparam int unsigned REQ_MIN_NS   = 20;
  // Strictly longer than the minimum, so one extra cycle
  localparam int unsigned REQ_MIN_CYC  = REQ_MIN_NS / CLK_NS + 1;
  localparam int unsigned TICK_NS      = 1000;
  localparam int unsigned TICK_CYC_DEF = TICK_NS / CLK_NS;
  localparam int unsigned TIME_W       = 18;
  localparam int unsigned TICK_W       = 16;
  localparam int unsigned REQ_W        = 4;
  localparam logic [TIME_W-1:0] TH_NOM_US_DEF = 18'h084d0;  // 34000 us
  localparam logic [TIME_W-1:0] TL_NOM_US_DEF = 18'h0fde8;  // 65000 us
  localparam logic [TIME_W-1:0] PERIOD_NOM_US = 18'h182b8;  // 99000 us

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {LVL_LOW, LVL_FLOAT, LVL_HIGH} rtpwm_lvl_t;
  typedef enum logic [1:0] {MODE_ONESHOT, MODE_CONT, MODE_CHAIN} rtpwm_mode_t;
  typedef enum logic [1:0] {RATE_QUARTER, RATE_NOMINAL, RATE_DBL_HIGH} rtpwm_rate_t;
  typedef enum logic [1:0] {ST_STRAP, ST_IDLE, ST_HIGH, ST_LOW} rtpwm_st_t;

  typedef struct packed {
    logic level;
    logic oe;
    logic series_res;
  } rtpwm_line_t;

  typedef struct packed {
    rtpwm_st_t          fsm;
    rtpwm_mode_t        mode;
    rtpwm_rate_t        rate;
    logic [TICK_W-1:0]  tick_cnt;
    logic [TIME_W-1:0]  time_cnt;
    logic [TIME_W-1:0]  phase_len;
    logic [REQ_W-1:0]   req_cnt;
    logic               req_armed;
    rtpwm_line_t        line;
  } rtpwm_state_t;

  localparam rtpwm_line_t  RST_LINE  = '{level: 1'b0, oe: 1'b0, series_res: 1'b0};
  localparam rtpwm_state_t RST_STATE = '{fsm: ST_STRAP, mode: MODE_CONT, rate: RATE_NOMINAL,
                                         tick_cnt: '0, time_cnt: '0, phase_len: '0,
                                         req_cnt: '0, req_armed: 1'b0, line: RST_LINE};

  // ****************************************************************
  // Rate scaling
  // ****************************************************************
  function automatic logic [TIME_W-1:0] rtpwm_scale_high(rtpwm_rate_t r, logic [TIME_W-1:0] t);
    logic [TIME_W-1:0] v;
    v = t;
    unique case (r)
      RATE_QUARTER:  v = t >> 2;
      RATE_NOMINAL:  v = t;
      RATE_DBL_HIGH: v = {t[TIME_W-2:0], 1'b0};
    endcase
    return (v == '0) ? {{(TIME_W-1){1'b0}}, 1'b1} : v;
  endfunction

  function automatic logic [TIME_W-1:0] rtpwm_scale_low(rtpwm_rate_t r, logic [TIME_W-1:0] t);
    logic [TIME_W-1:0] v;
    v = (r == RATE_NOMINAL) ? t : (t >> 2);
    return (v == '0) ? {{(TIME_W-1){1'b0}}, 1'b1} : v;
  endfunction

endpackage

/* File: dv/rtpwm_mcu_model.sv */
// Controller model that pulls the shared line low to request a one shot
`timescale 1ns/1ps

module rtpwm_mcu_model (
  input  wire logic clk_i,
  output logic      pull_o
);
  // ********
  // Request
  // ********
  initial pull_o = 1'b0;

  // Low for n whole cycles, released on a falling edge so the line floats back high
  task automatic request(input int unsigned n);
    @(negedge clk_i);
    pull_o = 1'b1;
    repeat (n) @(negedge clk_i);
    pull_o = 1'b0;
  endtask

  // ********
  // Decode
  // ********
  // Ratio of two counts from one clock, so neither clock's accuracy matters
  // Doubled high time needs the coefficient divided by eight
  function automatic int temp_x16(input logic dbl_high, input logic [31:0] hi,
                                  input logic [31:0] lo);
    real ratio;
    ratio = real'(hi) / real'(lo);
    if (dbl_high) return int'(16.0 * (421.0 - 93.875 * ratio));
    return int'(16.0 * (421.0 - 751.0 * ratio));
  endfunction
endmodule  // rtpwm_mcu_model

/* File: dv/rtpwm_output_tb_top.sv */
// Self-checking bench of the ratiometric temperature PWM output
`timescale 1ns/1ps

module rtpwm_output_tb_top;
  import rtpwm_pkg::*;
  localparam int unsigned       TICK = 2;
  localparam logic [TIME_W-1:0] TH   = 18'h0000a;

  logic              clk_i    = 1'b0;
  logic              rstn_i   = 1'b0;
  rtpwm_lvl_t        mode_pin = LVL_LOW;
  rtpwm_lvl_t        rate_pin = LVL_LOW;
  logic [TIME_W-1:0] low_us   = '0;
  logic              out_o, out_oe_o, series_res_en_o, busy_o, pull, line;
  logic [31:0]       lfsr     = 32'haff4;
  logic [31:0]       q_hi[$], q_lo[$];
  logic [31:0]       hi_c     = '0;
  logic [31:0]       lo_c     = '0;
  logic [31:0]       e_hi, e_lo;
  int unsigned       n_fail = 0, n_compared = 0, n_seen = 0;
  int                t_seen, t_exp;
  logic              dbl_rate = 1'b0;

  // ********
  // Harness
  // ********
  always #2 clk_i = ~clk_i;
  // Pull-up on the line; controller overpowers the series-resistor drive
  assign line = pull ? 1'b0 : (out_oe_o ? out_o : 1'b1);

  rtpwm_output #(.TH_NOM_US(TH), .TICK_CYC(TICK)) dut_u (
    .clk_i(clk_i), .rstn_i(rstn_i), .mode_select_pin_i(mode_pin),
    .rate_select_chain_input_pin_i(rate_pin), .low_time_us_i(low_us), .out_i(line),
    .out_o(out_o), .out_oe_o(out_oe_o), .series_res_en_o(series_res_en_o), .busy_o(busy_o));

  rtpwm_mcu_model mcu_u (.clk_i(clk_i), .pull_o(pull));

  // ********
  // Helpers
  // ********
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("Compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] scaled(input logic hi, input rtpwm_lvl_t r,
                                         input logic [31:0] t);
    logic [31:0] v;
    v = (r == LVL_FLOAT) ? t : ((hi && r == LVL_HIGH) ? t << 1 : t >> 2);
    if (v == '0) v = 32'h1;
    return v * TICK;
  endfunction

  task automatic expect_one(input rtpwm_lvl_t r);
    q_hi.push_back(scaled(1'b1, r, 32'(TH)));
    q_lo.push_back(scaled(1'b0, r, 32'(low_us)));
  endtask

  task automatic wait_seen(input int unsigned n);
    int unsigned k;
    k = 0;
    while (n_seen < n && k < 2000) begin
      @(negedge clk_i);
      k++;
    end
    check(n_seen >= n, 1'b1);
  endtask

  // ********
  // Monitor
  // ********
  // A waveform ends when busy drops or the line rises again after its low phase
  always @(negedge clk_i) begin
    if (!rstn_i) begin
      hi_c = '0;
      lo_c = '0;
    end else begin
      if (lo_c != 0 && (!busy_o || line)) begin
        n_seen++;
        if (q_hi.size() == 0) check(1'b0, 1'b1);
        else begin
          e_hi = q_hi.pop_front();
          e_lo = q_lo.pop_front();
          check(hi_c, e_hi);
          check(lo_c, e_lo);
          t_seen = mcu_u.temp_x16(dbl_rate, hi_c, lo_c);
          t_exp  = mcu_u.temp_x16(dbl_rate, e_hi, e_lo);
          check(t_seen, t_exp);
        end
        hi_c = '0;
        lo_c = '0;
      end
      if (busy_o) begin
        if (line) hi_c++;
        else lo_c++;
      end
    end
  end

  // ********
  // Scenarios
  // ********
  task automatic session(input rtpwm_lvl_t m, input rtpwm_lvl_t r);
    int unsigned base;
    rtpwm_lvl_t  eff;
    @(negedge clk_i);
    rstn_i   = 1'b0;
    mode_pin = m;
    rate_pin = (m == LVL_HIGH) ? LVL_FLOAT : r;
    lfsr     = lfsr_step(lfsr);
    low_us   = 18'(32'd8 + lfsr[3:0]);
    eff      = (m == LVL_HIGH) ? LVL_FLOAT : r;
    dbl_rate = (eff == LVL_HIGH);
    base     = n_seen;
    q_hi.delete();
    q_lo.delete();
    repeat (8) @(negedge clk_i);
    rstn_i = 1'b1;
    repeat (2) @(negedge clk_i);
    check(series_res_en_o, m == LVL_LOW);
    check(out_oe_o, 1'b1);
    if (m != LVL_HIGH) rate_pin = (r == LVL_LOW) ? LVL_HIGH : LVL_LOW;
    case (m)
      LVL_LOW: begin
        mcu_u.request(5);
        repeat (4) @(negedge clk_i);
        check(busy_o, 1'b0);
        expect_one(eff);
        mcu_u.request(6);
        check(busy_o, 1'b0);
        wait_seen(base + 1);
        repeat (40) @(negedge clk_i);
        check(n_seen == base + 1, 1'b1);
        check(busy_o, 1'b0);
      end
      LVL_FLOAT: begin
        expect_one(eff);
        expect_one(eff);
        wait_seen(base + 2);
      end
      default: begin
        rate_pin = LVL_LOW;
        repeat (6) @(negedge clk_i);
        rate_pin = LVL_FLOAT;
        expect_one(eff);
        wait_seen(base + 1);
      end
    endcase
    check(q_hi.size(), 32'h0);
  endtask

  initial begin
    for (int i = 0; i < 3; i++) begin
      for (int j = 0; j < 3; j++) begin
        session(rtpwm_lvl_t'(i), rtpwm_lvl_t'(j));
      end
    end
    complete_run;
  end

  // All sessions together need about a thousand cycles; this is far beyond that
  initial begin
    #100000;
    n_fail++;
    complete_run;
  end
endmodule  // rtpwm_output_tb_top
